/* efi_endpoint_fifo.sv */
// Functional notes
// - Eight 512-byte endpoint RAM blocks are the FIFO storage itself.
// - Each block is a 256 by 16 RAM; eight distinct blocks.
// - Blocks change owner by reassignment only, no data is copied.
// - USB-owned blocks use one port; I/O-owned blocks offer two ports.
// - Endpoints four and eight double buffer; two and six double, triple or quad.
// - Full speed uses only the first 64 bytes of each 512-byte buffer.
// - Endpoint zero bidirectional 64 bytes; endpoint one separate 64-byte in and out.
// - Eight setup bytes are held at E6B8 through E6BF.
// - Alternate settings 0 to 3 select endpoint types; four and eight are off in 0 and bulk in 1 to 3.
// - Buffers map at F000, E7C0, E780 and E740.
// - Master mode drives the FIFO select; ready pins are flag inputs.
// - The waveform engine runs from the internally derived interface clock.
// - Slave mode takes external strobes; byte or word width per endpoint.
// - Slave strobes act asynchronously as transfer strobes, not clock qualifiers.
// - Read, write, output enable and packet end act only under chip select.
// - A bit selects the 30 or 48 MHz divider; both come to 1, so the interface clock is 10 MHz; another inverts it.
// - Engine has three control outputs, two ready inputs, 8 or 16-bit data.
// - Each vector sets controls, ready condition, FIFO and address advance.
// - Control outputs may change on each interface clock edge, twice per cycle.
// - The engine tests ready pins and branches on them.
// - A two-bit field selects port, master or slave mode; port is default.
`timescale 1ns/1ps

// Staging FIFO between the pin side and the endpoint RAM write port.
module efi_stream_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic push, pop;

  // Pointers carry one extra bit so that full and empty differ.
  assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW + 1)'(push);
      rd_q <= rd_q + (AW + 1)'(pop);
    end
  end

  // Storage needs no reset; only entries between the pointers are read.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule

module efi_endpoint_fifo #(
  parameter int IFC48_DIV = efi_pkg::EFI_IFC48_DIV,
  parameter int IFC30_DIV = efi_pkg::EFI_IFC30_DIV,
  parameter int STAGE_DEPTH = efi_pkg::EFI_STAGE_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] interface_config,
  input wire logic interface_clock_sel_48,
  input wire logic interface_clock_invert,
  output logic interface_clock,
  input wire logic high_speed,
  input wire logic [1:0] alt_setting,
  input wire logic [7:0] ep_buffering,
  input wire logic [3:0] ep_word_mode,
  input wire logic [11:0] prog_level,
  input wire logic [7:0] block_owner_usb,
  input wire logic usb_we,
  input wire logic [10:0] usb_waddr,
  input wire logic [15:0] usb_wdata,
  output logic [15:0] usb_rdata,
  input wire logic usb_fill,
  input wire logic usb_take,
  input wire logic [1:0] usb_fifo,
  input wire logic [9:0] usb_bytes,
  input wire logic usb_small_we,
  input wire logic [7:0] usb_small_addr,
  input wire logic [7:0] usb_small_wdata,
  output logic [7:0] usb_small_rdata,
  input wire logic usb_setup_we,
  input wire logic [2:0] usb_setup_idx,
  input wire logic [7:0] usb_setup_data,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic [9:0] ep_types,
  input wire logic fifo_chip_select_n,
  input wire logic fifo_read_strobe,
  input wire logic fifo_write_strobe,
  input wire logic fifo_output_enable,
  input wire logic packet_commit_strobe,
  input wire logic [1:0] fifo_select_in,
  output logic [1:0] fifo_select_out,
  output logic fifo_select_oe,
  input wire logic [1:0] ready_in,
  input wire logic [15:0] fd_in,
  output logic [15:0] fd_out,
  output logic fd_oe,
  output logic flag_empty,
  output logic flag_full,
  output logic flag_prog,
  output logic packet_committed,
  output logic [1:0] packet_committed_fifo,
  input wire logic wave_wr,
  input wire logic [2:0] wave_idx,
  input wire logic [efi_pkg::EFI_VEC_W-1:0] wave_vec,
  input wire logic wave_start,
  input wire logic [1:0] wave_fifo,
  output logic [2:0] waveform_control_outputs,
  output logic [15:0] wave_addr,
  output logic wave_busy,
  output logic wave_done
);
  import efi_pkg::*;

  localparam int SYNC_W = 25;
  localparam int ST_W = 2 + EFI_WADDR_W + EFI_WORD_W;

  // Byte address to physical address: block plus offset inside its 512 bytes.
  function automatic logic [11:0] efi_phys(input logic [11:0] p, input logic [2:0] base, input logic hs);
    logic [2:0] blk;
    logic [8:0] off;
    blk = base + (hs ? {1'b0, p[10:9]} : {1'b0, p[7:6]});
    off = hs ? p[8:0] : {3'b000, p[5:0]};
    return {blk, off};
  endfunction

  function automatic logic [11:0] efi_wrap(input logic [11:0] p, input logic [11:0] add, input logic [11:0] cap);
    logic [12:0] s;
    s = {1'b0, p} + {1'b0, add};
    return (s >= {1'b0, cap}) ? 12'(s - {1'b0, cap}) : s[11:0];
  endfunction

  // Two flip-flops on every pin input; only the second stage is read.
  logic [SYNC_W-1:0] sync1_q, sync2_q;
  logic [2:0] strobe_prev_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      strobe_prev_q <= '0;
    end else begin
      sync1_q <= {fifo_chip_select_n, fifo_read_strobe, fifo_write_strobe, fifo_output_enable,
                  packet_commit_strobe, fifo_select_in, ready_in, fd_in};
      sync2_q <= sync1_q;
      strobe_prev_q <= {sync2_q[23:22], sync2_q[20]};
    end
  end

  logic s_cs, s_rd, s_wr, s_oe, s_pkt;
  logic [1:0] s_sel, s_rdy;
  logic [15:0] s_fd;
  assign s_cs = ~sync2_q[24];
  assign {s_rd, s_wr, s_oe, s_pkt, s_sel, s_rdy, s_fd} = sync2_q[23:0];

  // Mode decode; the reserved code behaves as port mode.
  logic mode_master, mode_slave;
  assign mode_master = interface_config == EFI_MODE_MASTER;
  assign mode_slave = interface_config == EFI_MODE_SLAVE;

  // Strobes act on their trailing edge, and only under chip select.
  logic slave_rd, slave_wr, slave_pkt;
  assign slave_rd = mode_slave & s_cs & strobe_prev_q[2] & ~s_rd;
  assign slave_wr = mode_slave & s_cs & strobe_prev_q[1] & ~s_wr;
  assign slave_pkt = mode_slave & s_cs & strobe_prev_q[0] & ~s_pkt;

  // Interface clock divider; the engine steps on its enable pulse.
  logic [7:0] ifc_cnt_q;
  logic ifc_phase_q, ifc_out_q, ifc_tick;
  logic [7:0] ifc_div;
  assign ifc_div = interface_clock_sel_48 ? 8'(IFC48_DIV) : 8'(IFC30_DIV);
  assign ifc_tick = ifc_cnt_q >= ifc_div - 8'h01;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ifc_cnt_q <= '0;
      ifc_phase_q <= 1'b0;
      ifc_out_q <= 1'b0;
    end else begin
      ifc_cnt_q <= ifc_tick ? 8'h00 : ifc_cnt_q + 8'h01;
      ifc_phase_q <= ifc_phase_q ^ ifc_tick;
      ifc_out_q <= (ifc_phase_q ^ ifc_tick) ^ interface_clock_invert;
    end
  end
  assign interface_clock = ifc_out_q;

  // Buffer counts and block placement per FIFO.
  logic [3:0][2:0] nbuf;
  logic [3:0][2:0] base;
  logic [11:0] pkt;
  assign pkt = high_speed ? EFI_HS_PKT : EFI_FS_PKT;
  assign nbuf[0] = (ep_buffering[1:0] == 2'b00) ? EFI_MIN_BUFS : {1'b0, ep_buffering[1:0]} + 3'h1;
  assign nbuf[1] = EFI_MIN_BUFS;
  assign nbuf[2] = (ep_buffering[5:4] == 2'b00) ? EFI_MIN_BUFS : {1'b0, ep_buffering[5:4]} + 3'h1;
  assign nbuf[3] = EFI_MIN_BUFS;
  assign base[0] = 3'h0;
  assign base[1] = nbuf[0];
  assign base[2] = nbuf[0] + EFI_MIN_BUFS;
  assign base[3] = nbuf[0] + EFI_MIN_BUFS + nbuf[2];

  // Waveform engine state.
  efi_wave_st_e wst_q;
  logic [2:0] vidx_q;
  logic [1:0] eng_sel_q;
  logic [2:0] ctl_q;
  logic [15:0] waddr_q;
  logic done_q;
  logic [EFI_VEC_W-1:0] vec_q [EFI_NUM_VECS];
  logic [EFI_VEC_W-1:0] v;
  logic v_cond, eng_step, eng_rd, eng_wr, eng_adv;
  assign v = vec_q[vidx_q];
  assign v_cond = ((s_rdy ^ v[EFI_VEC_VAL_LO +: 2]) & v[EFI_VEC_MASK_LO +: 2]) == 2'b00;
  assign eng_step = mode_master & (wst_q == EFI_WAVE_RUN) & ifc_tick;
  assign eng_rd = eng_step & v_cond & v[EFI_VEC_ADV_FIFO] & v[EFI_VEC_DIR_OUT];
  assign eng_wr = eng_step & v_cond & v[EFI_VEC_ADV_FIFO] & ~v[EFI_VEC_DIR_OUT];

  // Selected FIFO: the engine drives it in master mode, the pins in slave mode.
  logic [1:0] sel;
  assign sel = mode_master ? eng_sel_q : s_sel;

  // Per-FIFO state, collected for the shared datapath.
  logic [3:0][11:0] cnt_all, wp_all, rp_all, cap_all;
  logic [3:0] full_all, empty_all, prog_all;
  logic [11:0] step_sel;
  logic wr_req, rd_req, wr_acc, rd_acc, st_in_ready, st_out_valid, st_out_ready;
  logic [11:0] wr_phys, rd_phys;
  assign step_sel = ep_word_mode[sel] ? 12'h002 : 12'h001;
  assign wr_req = slave_wr | eng_wr;
  assign rd_req = slave_rd | eng_rd;
  assign wr_phys = efi_phys(wp_all[sel], base[sel], high_speed);
  assign rd_phys = efi_phys(rp_all[sel], base[sel], high_speed);
  // Writes need room in the FIFO and in the staging buffer.
  assign wr_acc = wr_req & ~full_all[sel] & st_in_ready;
  // Reads wait until staged writes have landed and the block belongs to I/O.
  assign rd_acc = rd_req & ~empty_all[sel] & ~st_out_valid & ~block_owner_usb[rd_phys[11:9]];
  assign eng_adv = ~v[EFI_VEC_ADV_FIFO] | (v[EFI_VEC_DIR_OUT] ? rd_acc : wr_acc);

  genvar f;
  generate
    for (f = 0; f < EFI_NUM_FIFOS; f++) begin : g_fifo
      logic [11:0] cnt_q, wp_q, rp_q, step, nbytes, cap;
      logic wr_hit, rd_hit, fill_hit, take_hit;
      assign cap = 12'(nbuf[f] * pkt);
      assign step = ep_word_mode[f] ? 12'h002 : 12'h001;
      assign nbytes = {2'b00, usb_bytes};
      assign wr_hit = wr_acc & (sel == 2'(f));
      assign rd_hit = rd_acc & (sel == 2'(f));
      assign fill_hit = usb_fill & (usb_fifo == 2'(f));
      assign take_hit = usb_take & (usb_fifo == 2'(f));
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cnt_q <= '0;
          wp_q <= '0;
          rp_q <= '0;
        end else begin
          cnt_q <= cnt_q + (wr_hit ? step : 12'h000) + (fill_hit ? nbytes : 12'h000)
                   - (rd_hit ? step : 12'h000) - (take_hit ? nbytes : 12'h000);
          wp_q <= efi_wrap(wp_q, (wr_hit ? step : 12'h000) + (fill_hit ? nbytes : 12'h000), cap);
          rp_q <= efi_wrap(rp_q, (rd_hit ? step : 12'h000) + (take_hit ? nbytes : 12'h000), cap);
        end
      end
      assign cnt_all[f] = cnt_q;
      assign wp_all[f] = wp_q;
      assign rp_all[f] = rp_q;
      assign cap_all[f] = cap;
      assign full_all[f] = ({1'b0, cnt_q} + {1'b0, step}) > {1'b0, cap};
      assign empty_all[f] = cnt_q < step;
      assign prog_all[f] = cnt_q >= prog_level;
    end
  endgenerate

  // Byte mode places a byte on the lane chosen by the address bit.
  logic [ST_W-1:0] st_in, st_out;
  logic [1:0] st_lanes;
  logic [15:0] st_wdata;
  assign st_lanes = ep_word_mode[sel] ? 2'b11 : (wr_phys[0] ? 2'b10 : 2'b01);
  assign st_wdata = ep_word_mode[sel] ? s_fd : {s_fd[7:0], s_fd[7:0]};
  assign st_in = {st_lanes, wr_phys[11:1], st_wdata};
  // The RAM write port stalls while the target block is held by the USB engine.
  assign st_out_ready = ~block_owner_usb[st_out[ST_W-3 -: EFI_BLK_W]];

  efi_stream_fifo #(
    .WIDTH(ST_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(wr_acc),
    .in_ready(st_in_ready),
    .in_data(st_in),
    .out_valid(st_out_valid),
    .out_ready(st_out_ready),
    .out_data(st_out)
  );

  // Endpoint RAM: eight 256x16 blocks as one array, block number in the top bits.
  logic [15:0] ram_q [EFI_NUM_BLOCKS * EFI_BLOCK_WORDS];
  logic [7:0] small_q [EFI_SMALL_BYTES];
  logic [7:0] setup_q [EFI_SETUP_BYTES];
  logic [10:0] st_waddr, cpu_big_waddr;
  logic st_we, cpu_big, cpu_small, cpu_setup, cpu_big_we, usb_own_we;
  logic [7:0] cpu_small_idx;
  logic [15:0] head_word, usb_word, cpu_word;
  assign st_waddr = st_out[EFI_WORD_W +: EFI_WADDR_W];
  assign st_we = st_out_valid & st_out_ready;
  assign usb_own_we = usb_we & block_owner_usb[usb_waddr[10:8]];
  assign cpu_big = cpu_addr >= EFI_ADDR_BIG;
  assign cpu_small = (cpu_addr >= EFI_ADDR_EP0) & (cpu_addr <= EFI_ADDR_SMALL_END);
  assign cpu_setup = (cpu_addr >= EFI_ADDR_SETUP) & (cpu_addr <= EFI_ADDR_SETUP_END);
  assign cpu_big_waddr = cpu_addr[11:1];
  assign cpu_big_we = cpu_wr & cpu_big & ~block_owner_usb[cpu_addr[11:9]];
  assign cpu_small_idx = 8'(cpu_addr - EFI_ADDR_EP0);
  assign head_word = ram_q[rd_phys[11:1]];
  assign usb_word = ram_q[usb_waddr];
  assign cpu_word = ram_q[cpu_big_waddr];

  // One port for the USB side, a write and a read port plus processor bytes for I/O.
  always_ff @(posedge clk) begin
    if (usb_own_we) begin
      ram_q[usb_waddr] <= usb_wdata;
    end
    if (st_we && st_out[ST_W-2]) begin
      ram_q[st_waddr][7:0] <= st_out[7:0];
    end
    if (st_we && st_out[ST_W-1]) begin
      ram_q[st_waddr][15:8] <= st_out[15:8];
    end
    if (cpu_big_we && !cpu_addr[0]) begin
      ram_q[cpu_big_waddr][7:0] <= cpu_wdata;
    end
    if (cpu_big_we && cpu_addr[0]) begin
      ram_q[cpu_big_waddr][15:8] <= cpu_wdata;
    end
  end

  // Endpoint zero and one buffers and the setup bytes.
  always_ff @(posedge clk) begin
    if (usb_small_we) begin
      small_q[usb_small_addr] <= usb_small_wdata;
    end else if (cpu_wr && cpu_small) begin
      small_q[cpu_small_idx] <= cpu_wdata;
    end
    if (usb_setup_we) begin
      setup_q[usb_setup_idx] <= usb_setup_data;
    end
  end

  // Registered read data on every port.
  logic [15:0] fd_out_q, usb_rdata_q;
  logic [7:0] small_rdata_q, cpu_rdata_q, cpu_rd_d;
  assign cpu_rd_d = cpu_big ? (cpu_addr[0] ? cpu_word[15:8] : cpu_word[7:0])
                  : cpu_small ? small_q[cpu_small_idx]
                  : cpu_setup ? setup_q[cpu_addr[2:0]] : 8'h00;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fd_out_q <= '0;
      usb_rdata_q <= '0;
      small_rdata_q <= '0;
      cpu_rdata_q <= '0;
    end else begin
      fd_out_q <= ep_word_mode[sel] ? head_word : {8'h00, rd_phys[0] ? head_word[15:8] : head_word[7:0]};
      usb_rdata_q <= usb_word;
      small_rdata_q <= small_q[usb_small_addr];
      cpu_rdata_q <= cpu_rd_d;
    end
  end
  assign fd_out = fd_out_q;
  assign usb_rdata = usb_rdata_q;
  assign usb_small_rdata = small_rdata_q;
  assign cpu_rdata = cpu_rdata_q;

  // The bus drives only under chip select and output enable, or on an engine output vector.
  assign fd_oe = (mode_slave & s_cs & s_oe) | (mode_master & (wst_q == EFI_WAVE_RUN) & v[EFI_VEC_DIR_OUT]);
  assign fifo_select_out = eng_sel_q;
  assign fifo_select_oe = mode_master;

  // Waveform engine: one vector per interface clock edge, held or branched until its ready condition.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wst_q <= EFI_WAVE_IDLE;
      vidx_q <= '0;
      eng_sel_q <= '0;
      ctl_q <= EFI_CTL_RESET;
      waddr_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (wst_q)
        EFI_WAVE_IDLE: begin
          if (wave_start && mode_master) begin
            wst_q <= EFI_WAVE_RUN;
            vidx_q <= '0;
            eng_sel_q <= wave_fifo;
          end
        end
        EFI_WAVE_RUN: begin
          if (!mode_master) begin
            wst_q <= EFI_WAVE_IDLE;
          end else if (eng_step) begin
            ctl_q <= v[EFI_VEC_CTL_LO +: 3];
            if (v_cond && eng_adv) begin
              waddr_q <= waddr_q + {15'h0000, v[EFI_VEC_ADV_ADDR]};
              if (v[EFI_VEC_LAST]) begin
                wst_q <= EFI_WAVE_IDLE;
                done_q <= 1'b1;
              end else begin
                vidx_q <= v[EFI_VEC_NEXT_LO +: 3];
              end
            end else if (!v_cond && v[EFI_VEC_BR_EN]) begin
              vidx_q <= v[EFI_VEC_BR_LO +: 3];
            end
          end
        end
        default: wst_q <= EFI_WAVE_IDLE;
      endcase
    end
  end

  // Vectors are loaded only while the engine is idle.
  always_ff @(posedge clk) begin
    if (wave_wr && wst_q == EFI_WAVE_IDLE) begin
      vec_q[wave_idx] <= wave_vec;
    end
  end
  assign waveform_control_outputs = ctl_q;
  assign wave_addr = waddr_q;
  assign wave_busy = wst_q == EFI_WAVE_RUN;
  assign wave_done = done_q;

  // Flags for the selected FIFO, packet commit and endpoint types.
  logic fe_q, ff_q, fp_q, pc_q;
  logic [1:0] pcf_q;
  logic [9:0] ept_q;
  logic [1:0] t126;
  logic [1:0] t4;
  assign t126 = (alt_setting == 2'd1) ? EFI_EP_BULK : (alt_setting == 2'd0) ? EFI_EP_OFF : EFI_EP_INT;
  assign t4 = (alt_setting == 2'd0) ? EFI_EP_OFF : EFI_EP_BULK;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fe_q <= 1'b1;
      ff_q <= 1'b0;
      fp_q <= 1'b0;
      pc_q <= 1'b0;
      pcf_q <= '0;
      ept_q <= '0;
    end else begin
      fe_q <= empty_all[sel];
      ff_q <= full_all[sel];
      fp_q <= prog_all[sel];
      pc_q <= slave_pkt;
      pcf_q <= slave_pkt ? sel : pcf_q;
      ept_q <= {t4, (alt_setting == 2'd3) ? EFI_EP_ISO : t126, t4,
                (alt_setting == 2'd3) ? EFI_EP_ISO : t126, t126};
    end
  end
  assign flag_empty = fe_q;
  assign flag_full = ff_q;
  assign flag_prog = fp_q;
  assign packet_committed = pc_q;
  assign packet_committed_fifo = pcf_q;
  assign ep_types = ept_q;
endmodule

/* efi_endpoint_fifo_chk.sv */
`timescale 1ns/1ps
// Watches the pin side and the waveform engine of the endpoint FIFO block.
module efi_endpoint_fifo_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] interface_config,
  input wire logic interface_clock_invert,
  input wire logic interface_clock,
  input wire logic fifo_chip_select_n,
  input wire logic fifo_select_oe,
  input wire logic fd_oe,
  input wire logic flag_empty,
  input wire logic flag_full,
  input wire logic packet_committed,
  input wire logic wave_start,
  input wire logic wave_busy,
  input wire logic wave_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A start accepted while idle in master mode, and a slave port left unselected long enough to pass the synchronisers.
  sequence s_start; wave_start && !wave_busy && interface_config == 2'b10; endsequence
  sequence s_cs_off; (fifo_chip_select_n && interface_config == 2'b11) [*4]; endsequence
  property p_start; s_start |=> wave_busy; endproperty
  a_start: assert property (p_start) else $error("busy missing after start");
  property p_done; wave_done |=> !wave_done && !wave_busy; endproperty
  a_done: assert property (p_done) else $error("done not a single pulse");
  property p_master; (interface_config == 2'b10) [*3] |-> fifo_select_oe; endproperty
  a_master: assert property (p_master) else $error("select not driven in master mode");
  property p_port; (interface_config != 2'b10) [*3] |-> !fifo_select_oe; endproperty
  a_port: assert property (p_port) else $error("select driven outside master mode");
  property p_cs_oe; s_cs_off |-> !fd_oe; endproperty
  a_cs_oe: assert property (p_cs_oe) else $error("data driven without chip select");
  property p_cs_pkt; s_cs_off |-> !packet_committed; endproperty
  a_cs_pkt: assert property (p_cs_pkt) else $error("commit without chip select");
  property p_flags; !(flag_empty && flag_full); endproperty
  a_flags: assert property (p_flags) else $error("empty and full together");
  // Skips the first edge after reset and the two edges around a change of the inversion bit.
  property p_interface_clock;
    $past(rst_b) && $stable(interface_clock_invert) && $past(interface_clock_invert, 2) == interface_clock_invert
      |-> interface_clock != $past(interface_clock);
  endproperty
  a_interface_clock: assert property (p_interface_clock) else $error("interface clock missed a tick");
endmodule

bind efi_endpoint_fifo efi_endpoint_fifo_chk i_chk (.clk(clk), .rst_b(rst_b), .interface_config(interface_config),
  .interface_clock_invert(interface_clock_invert), .interface_clock(interface_clock), .fifo_chip_select_n(fifo_chip_select_n),
  .fifo_select_oe(fifo_select_oe), .fd_oe(fd_oe), .flag_empty(flag_empty), .flag_full(flag_full),
  .packet_committed(packet_committed), .wave_start(wave_start), .wave_busy(wave_busy), .wave_done(wave_done));

/* efi_endpoint_fifo_tb_top.sv */
`timescale 1ns/1ps
module efi_endpoint_fifo_tb_top;
  import efi_pkg::*;
  logic clk = 0, rst_b = 0, interface_clock_sel_48 = 1, interface_clock_invert = 0, high_speed = 0, usb_we = 0, usb_fill = 0;
  logic usb_take = 0, usb_small_we = 0, usb_setup_we = 0, cpu_wr = 0, wave_wr = 0, wave_start = 0, pk_seen = 0;
  logic [1:0] interface_config = 2'h3, alt_setting = '0, usb_fifo = '0, wave_fifo = '0, ready_in = '0;
  logic [7:0] ep_buffering = '0, block_owner_usb = '0, usb_small_addr = 8'h40, usb_small_wdata, usb_setup_data;
  logic [7:0] cpu_wdata = '0, usb_small_rdata, cpu_rdata;
  logic [3:0] ep_word_mode = 4'hf;
  logic [11:0] prog_level = 12'h004;
  logic [10:0] usb_waddr = '0;
  logic [15:0] usb_wdata = '0, cpu_addr = '0, usb_rdata, fd_out, fd_in, wave_addr, w;
  logic [9:0] usb_bytes = '0, ep_types;
  logic [9:0] tbl [4] = '{10'h000, 10'h155, 10'h19a, 10'h1de};
  logic [2:0] usb_setup_idx = 3'h3, wave_idx = '0, waveform_control_outputs;
  logic [EFI_VEC_W-1:0] wave_vec = 18'h2_0002;
  logic [1:0] fifo_select_in, fifo_select_out, packet_committed_fifo;
  logic interface_clock, fifo_select_oe, fd_oe, flag_empty, flag_full, flag_prog, packet_committed, wave_busy;
  logic wave_done, fifo_chip_select_n, fifo_read_strobe, fifo_write_strobe, fifo_output_enable, packet_commit_strobe;
  int n_mismatch = 0, checked = 0, cyc = 0, seed = 32'h3eb3, k;
  logic [15:0] exp_q [$];
  always #25 clk = ~clk;
  efi_endpoint_fifo i_dut (.*);
  efi_ext_master i_ext (.*);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The watcher pairs each read the far side makes with the oldest word written.
  always @(i_ext.look) chk("fd_out", exp_q.pop_front(), fd_out);
  // A hang is cut short well after the longest expected run.
  always @(posedge clk) begin
    cyc++;
    pk_seen <= pk_seen | packet_committed;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    usb_small_wdata = $random(seed);
    usb_setup_data = $random(seed);
    repeat (4) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    i_ext.xfer(2'h0, 16'h1234, 1'b1);
    repeat (5) @(negedge clk);
    chk("flag_empty", 16'h0001, {15'h0, flag_empty});
    // Double buffering at full speed holds 128 bytes; the last write must be refused.
    for (k = 0; k < 65; k++) begin
      w = $random(seed);
      if (k < 64) exp_q.push_back(w);
      i_ext.xfer(2'h0, w, 1'b0);
    end
    repeat (6) @(negedge clk);
    chk("full_prog", 16'h0003, {14'h0, flag_full, flag_prog});
    i_ext.xfer(2'h2, 16'h0000, 1'b0);
    repeat (2) @(negedge clk);
    chk("committed", 16'h0001, {15'h0, pk_seen});
    repeat (64) i_ext.xfer(2'h1, 16'h0000, 1'b0);
    repeat (6) @(negedge clk);
    chk("flag_empty", 16'h0001, {15'h0, flag_empty});
    $display("slave test ended");
    interface_config = 2'h2;
    interface_clock_invert = 1;
    wave_wr = 1;
    @(negedge clk) wave_wr = 0;
    wave_start = 1;
    @(negedge clk) wave_start = 0;
    for (k = 0; k < 40 && wave_done !== 1'b1; k++) begin
      @(negedge clk);
    end
    chk("wave", 16'h0005, {12'h0, waveform_control_outputs, wave_done});
    for (k = 0; k < 4; k++) begin
      alt_setting = k[1:0];
      repeat (2) @(negedge clk);
      chk("ep_types", {6'h0, tbl[k]}, {6'h0, ep_types});
    end
    usb_setup_we = 1;
    usb_small_we = 1;
    @(negedge clk) {usb_setup_we, usb_small_we} = 2'h0;
    cpu_addr = 16'he6bb;
    repeat (2) @(negedge clk);
    chk("setup", {8'h0, usb_setup_data}, {8'h0, cpu_rdata});
    cpu_addr = 16'he780;
    repeat (2) @(negedge clk);
    chk("endpoint_one_out_buffer", {8'h0, usb_small_wdata}, {8'h0, cpu_rdata});
    $display("master and map tests ended");
    complete_run;
  end
endmodule

/* efi_ext_master.sv */
`timescale 1ns/1ps
// External logic driving the asynchronous slave pins.
module efi_ext_master (
  input wire logic clk,
  output logic fifo_chip_select_n,
  output logic fifo_read_strobe,
  output logic fifo_write_strobe,
  output logic fifo_output_enable,
  output logic packet_commit_strobe,
  output logic [1:0] fifo_select_in,
  output logic [15:0] fd_in
);
  event look;
  initial begin
    {fifo_chip_select_n, fifo_read_strobe, fifo_write_strobe, fifo_output_enable, packet_commit_strobe} = 5'h10;
    fifo_select_in = 2'h0;
    fd_in = 16'h0000;
  end
  // Kind 0 writes, 1 reads, 2 ends a packet; off keeps the port unselected.
  // Strobes stay high and low two clocks each so the synchronisers see every edge.
  task automatic xfer(input logic [1:0] kind, input logic [15:0] d, input logic off);
    @(negedge clk);
    fifo_chip_select_n = off;
    fifo_output_enable = (kind == 2'h1);
    fd_in = (kind == 2'h1) ? ~fd_in : d;
    repeat (6) @(negedge clk);
    if (kind == 2'h1) -> look;
    {fifo_read_strobe, fifo_write_strobe, packet_commit_strobe} = {kind == 2'h1, kind == 2'h0, kind == 2'h2};
    repeat (2) @(negedge clk);
    {fifo_read_strobe, fifo_write_strobe, packet_commit_strobe} = 3'h0;
    repeat (2) @(negedge clk);
    {fifo_chip_select_n, fifo_output_enable} = 2'h2;
    fd_in = ~fd_in; // A released bus never shows the old word.
  endtask
endmodule

/* efi_pkg.sv */
package efi_pkg;

  // Endpoint RAM organisation.
  localparam int EFI_NUM_BLOCKS = 8;
  localparam int EFI_BLOCK_WORDS = 256;
  localparam int EFI_WORD_W = 16;
  localparam int EFI_NUM_FIFOS = 4;
  localparam int EFI_BLK_W = 3;
  localparam int EFI_PTR_W = 12;
  localparam int EFI_WADDR_W = 11;
  localparam logic [11:0] EFI_HS_PKT = 12'h200;
  localparam logic [11:0] EFI_FS_PKT = 12'h040;
  localparam logic [2:0] EFI_MIN_BUFS = 3'h2;
  localparam int EFI_STAGE_DEPTH = 32;

  // Processor view of the endpoint buffers.
  localparam logic [15:0] EFI_ADDR_BIG = 16'hF000;
  localparam logic [15:0] EFI_ADDR_ENDPOINT_ONE_IN_BUFFER = 16'hE7C0;
  localparam logic [15:0] EFI_ADDR_ENDPOINT_ONE_OUT_BUFFER = 16'hE780;
  localparam logic [15:0] EFI_ADDR_EP0 = 16'hE740;
  localparam logic [15:0] EFI_ADDR_SMALL_END = 16'hE7FF;
  localparam logic [15:0] EFI_ADDR_SETUP = 16'hE6B8;
  localparam logic [15:0] EFI_ADDR_SETUP_END = 16'hE6BF;
  localparam int EFI_SMALL_BYTES = 192;
  localparam int EFI_SETUP_BYTES = 8;

  // Interface modes selected by the two-bit configuration field.
  typedef enum logic [1:0] {
    EFI_MODE_PORT = 2'b00,
    EFI_MODE_RSVD = 2'b01,
    EFI_MODE_MASTER = 2'b10,
    EFI_MODE_SLAVE = 2'b11
  } efi_mode_e;

  typedef enum logic [1:0] {
    EFI_EP_OFF = 2'b00,
    EFI_EP_BULK = 2'b01,
    EFI_EP_INT = 2'b10,
    EFI_EP_ISO = 2'b11
  } efi_ep_type_e;

  typedef enum logic {
    EFI_WAVE_IDLE = 1'b0,
    EFI_WAVE_RUN = 1'b1
  } efi_wave_st_e;

  // Waveform vector layout.
  localparam int EFI_VEC_W = 18;
  localparam int EFI_NUM_VECS = 8;
  localparam int EFI_VEC_CTL_LO = 0;
  localparam int EFI_VEC_MASK_LO = 3;
  localparam int EFI_VEC_VAL_LO = 5;
  localparam int EFI_VEC_ADV_FIFO = 7;
  localparam int EFI_VEC_DIR_OUT = 8;
  localparam int EFI_VEC_ADV_ADDR = 9;
  localparam int EFI_VEC_NEXT_LO = 10;
  localparam int EFI_VEC_BR_EN = 13;
  localparam int EFI_VEC_BR_LO = 14;
  localparam int EFI_VEC_LAST = 17;
  localparam logic [2:0] EFI_CTL_RESET = 3'h7;

  // Interface clock periods in tenths of a nanosecond.
  localparam int EFI_CLK_NS_X10 = 500;
  localparam int EFI_IFC48_NS_X10 = 208;
  localparam int EFI_IFC30_NS_X10 = 333;
  localparam int EFI_IFC48_DIV_RAW = EFI_IFC48_NS_X10 / EFI_CLK_NS_X10;
  localparam int EFI_IFC30_DIV_RAW = EFI_IFC30_NS_X10 / EFI_CLK_NS_X10;
  localparam int EFI_IFC48_DIV = (EFI_IFC48_DIV_RAW < 1) ? 1 : EFI_IFC48_DIV_RAW;
  localparam int EFI_IFC30_DIV = (EFI_IFC30_DIV_RAW < 1) ? 1 : EFI_IFC30_DIV_RAW;

endpackage
